/* File: pfl_pkg.sv */
// package for the pwm fault, lockout and trigger block
// assumes an apb master with 32-bit data and a 100 MHz clock
package pfl_pkg;
    localparam logic [11:0] FAULT_CFG_ADDR = 12'h000;
    localparam logic [11:0] CONTROL_ADDR = 12'h004;
    localparam logic [11:0] TRIG_CMP_LO_ADDR = 12'h008;
    localparam logic [11:0] TRIG_CMP_HI_ADDR = 12'h00c;
    localparam logic [11:0] PERIOD_ADDR = 12'h010;
    localparam logic [11:0] DUTY0_ADDR = 12'h014;
    localparam logic [11:0] STATUS_ADDR = 12'h024;
    localparam int DUTY_CNT = 4;
    // fault_configuration bit positions
    localparam int FA_EN_BIT = 0;
    localparam int FA_MODE_BIT = 1;
    localparam int FA_FLAG_BIT = 2;
    localparam int SCOPE_BIT = 3;
    localparam int FB_EN_BIT = 4;
    localparam int FB_MODE_BIT = 5;
    localparam int FB_FLAG_BIT = 6;
    localparam int BRK_EN_BIT = 7;
    // control register bit positions
    localparam int LOCKOUT_BIT = 1;
    localparam int TRIG_DIR_BIT = 3;
    localparam int POSTSCALE_LSB = 4;
    localparam logic [7:0] FAULT_CFG_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [3:0] POST_RESET = 4'h0;

    typedef enum logic [1:0] {
        TB_FREE,
        TB_SINGLE,
        TB_UPDOWN,
        TB_UPDOWN_INT
    } pfl_tb_mode_t;

    typedef struct packed {
        logic [15:0] count;
        logic countDown;
        logic periodStart;
        pfl_tb_mode_t mode;
    } pfl_time_base_t;

    typedef struct packed {
        logic highSidePolarity;
        logic lowSidePolarity;
        logic resetPinConfig;
        logic eightOutputs;
    } pfl_straps_t;
endpackage : pfl_pkg

/* File: pfl_fault_lockout_trigger.sv */
// fault protection, update lockout and special event trigger of a pwm unit
// assumes time base and pwm generator outside; time base on the same clock
//
// The register addresses and the APB interface to the registers were left to the implementer.
module pfl_fault_lockout_trigger (
    input wire logic clock,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic faultInANeg,
    input wire logic faultInBNeg,
    input wire logic breakpointHit,
    input wire pfl_pkg::pfl_straps_t straps,
    input wire pfl_pkg::pfl_time_base_t timeBase,
    input wire logic [7:0] pwmRaw,
    output logic [7:0] pwmOut,
    output logic [15:0] periodActive,
    output logic [15:0] dutyActive [pfl_pkg::DUTY_CNT],
    output logic specialTrigger
);
    import pfl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // registers and synchronisers
    logic [7:0] faultCfg_r;
    logic [7:0] control_r;
    logic [15:0] trigCmp_r;
    logic [15:0] periodBuf_r;
    logic [15:0] dutyBuf_r [DUTY_CNT];
    logic [1:0] syncA_r;
    logic [1:0] syncB_r;
    logic [1:0] syncBrk_r;

    logic [3:0] postCnt_r;
    logic faultForce_r;
    logic faultA;
    logic faultB;
    logic brkFault;

    logic wrStrobe;
    logic rdStrobe;
    logic addrHit;
    logic trigMatch;

    logic fltAHold;
    logic fltBHold;

    // fault lines idle high, so the synchronisers reset high and no false fault follows reset
    always_ff @(posedge clock) begin
        if (rst) begin
            syncA_r <= 2'h3;
        end else begin
            syncA_r <= {syncA_r[0], faultInANeg};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            syncB_r <= 2'h3;
        end else begin
            syncB_r <= {syncB_r[0], faultInBNeg};
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            syncBrk_r <= 2'h0;
        end else begin
            syncBrk_r <= {syncBrk_r[0], breakpointHit};
        end
    end

    assign faultA = faultCfg_r[FA_EN_BIT] && !syncA_r[1];
    assign faultB = straps.eightOutputs && faultCfg_r[FB_EN_BIT] && !syncB_r[1];
    assign brkFault = faultCfg_r[BRK_EN_BIT] && straps.resetPinConfig && syncBrk_r[1];

    ////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait states, unmapped addresses answer with pslverr
    assign wrStrobe = psel && penable && pwrite;
    assign rdStrobe = psel && penable && !pwrite;

    always_comb begin
        addrHit = 1'b0;
        case (paddr)
            FAULT_CFG_ADDR, CONTROL_ADDR: begin
                addrHit = 1'b1;
            end
            TRIG_CMP_LO_ADDR, TRIG_CMP_HI_ADDR: begin
                addrHit = 1'b1;
            end
            PERIOD_ADDR, STATUS_ADDR: begin
                addrHit = 1'b1;
            end
            default: begin
                for (int i = 0; i < DUTY_CNT; i++) begin
                    if (paddr == DUTY0_ADDR + 12'(4 * i)) begin
                        addrHit = 1'b1;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && !addrHit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // fault configuration: flags set by hardware, set wins over a clear
    // flag stays while its input is live so a clear from software cannot drop it
    assign fltAHold = faultCfg_r[FA_FLAG_BIT] && (faultA || !faultCfg_r[FA_MODE_BIT] || !timeBase.periodStart);
    assign fltBHold = faultCfg_r[FB_FLAG_BIT] && (faultB || !faultCfg_r[FB_MODE_BIT] || !timeBase.periodStart);

    always_ff @(posedge clock) begin
        if (rst) begin
            faultCfg_r <= FAULT_CFG_RESET;
        end else begin
            logic [7:0] nxt;
            nxt = faultCfg_r;
            if (wrStrobe && pready && paddr == FAULT_CFG_ADDR) begin
                nxt = pwdata[7:0];
                // software may only clear a flag, never set it
                nxt[FA_FLAG_BIT] = faultCfg_r[FA_FLAG_BIT] && pwdata[FA_FLAG_BIT];
                nxt[FB_FLAG_BIT] = faultCfg_r[FB_FLAG_BIT] && pwdata[FB_FLAG_BIT];
            end else begin
                nxt[FA_FLAG_BIT] = fltAHold;
                nxt[FB_FLAG_BIT] = fltBHold;
            end
            if (faultA) begin
                nxt[FA_FLAG_BIT] = 1'b1;
            end
            if (faultB) begin
                nxt[FB_FLAG_BIT] = 1'b1;
            end
            if (!straps.eightOutputs) begin
                nxt[FB_EN_BIT] = 1'b0;
                nxt[FB_MODE_BIT] = 1'b0;
                nxt[FB_FLAG_BIT] = 1'b0;
            end
            faultCfg_r <= nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            faultForce_r <= 1'b0;
        end else begin
            // flag covers both modes: cycle mode releases at period start, inactive mode on clear
            faultForce_r <= faultA || faultB || brkFault || faultCfg_r[FA_FLAG_BIT]
                || faultCfg_r[FB_FLAG_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output forcing; odd outputs are high side, even ones low side
    generate
        for (genvar g = 0; g < 8; g++) begin : gOut
            localparam logic HIGH_SIDE = (g % 2) == 1;
            logic inactiveLevel;
            logic forced;
            assign inactiveLevel = HIGH_SIDE ? !straps.highSidePolarity : !straps.lowSidePolarity;
            if (g < 6) begin : gLow
                assign forced = faultForce_r;
            end else begin : gHigh
                assign forced = faultForce_r && faultCfg_r[SCOPE_BIT] && straps.eightOutputs;
            end
            always_ff @(posedge clock) begin
                if (rst) begin
                    pwmOut[g] <= 1'b0;
                end else begin
                    pwmOut[g] <= forced ? inactiveLevel : (pwmRaw[g] ^ inactiveLevel);
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // control, compare and buffered values
    always_ff @(posedge clock) begin
        if (rst) begin
            control_r <= CONTROL_RESET;
        end else if (wrStrobe && pready && paddr == CONTROL_ADDR) begin
            control_r <= pwdata[7:0];
        end
    end

    // compare is written as two bytes; each half loads on its own
    always_ff @(posedge clock) begin
        if (rst) begin
            trigCmp_r <= VALUE_RESET;
        end else if (wrStrobe && pready) begin
            if (paddr == TRIG_CMP_LO_ADDR) begin
                trigCmp_r[7:0] <= pwdata[7:0];
            end
            if (paddr == TRIG_CMP_HI_ADDR) begin
                trigCmp_r[15:8] <= pwdata[7:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            periodBuf_r <= VALUE_RESET;
        end else if (wrStrobe && pready && paddr == PERIOD_ADDR) begin
            periodBuf_r <= pwdata[15:0];
        end
    end

    generate
        for (genvar d = 0; d < DUTY_CNT; d++) begin : gDuty
            always_ff @(posedge clock) begin
                if (rst) begin
                    dutyBuf_r[d] <= VALUE_RESET;
                end else if (wrStrobe && pready && paddr == DUTY0_ADDR + 12'(4 * d)) begin
                    dutyBuf_r[d] <= pwdata[15:0];
                end
            end

            // active copy follows its buffer whenever the lockout is clear
            always_ff @(posedge clock) begin
                if (rst) begin
                    dutyActive[d] <= VALUE_RESET;
                end else if (!control_r[LOCKOUT_BIT]) begin
                    dutyActive[d] <= dutyBuf_r[d];
                end
            end
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (rst) begin
            periodActive <= VALUE_RESET;
        end else if (!control_r[LOCKOUT_BIT]) begin
            periodActive <= periodBuf_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // special event trigger with postscaler, no enable
    always_comb begin
        trigMatch = timeBase.count == trigCmp_r;
        if (timeBase.mode == TB_UPDOWN || timeBase.mode == TB_UPDOWN_INT) begin
            trigMatch = trigMatch && (timeBase.countDown == control_r[TRIG_DIR_BIT]);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            postCnt_r <= POST_RESET;
            specialTrigger <= 1'b0;
        end else begin
            specialTrigger <= 1'b0;
            if (wrStrobe && pready && (paddr == TRIG_CMP_LO_ADDR || paddr == TRIG_CMP_HI_ADDR)) begin
                postCnt_r <= POST_RESET;
            end else if (trigMatch) begin
                // at or above: lowering the ratio mid-count must not stall until the count wraps
                if (postCnt_r >= control_r[POSTSCALE_LSB +: 4]) begin
                    postCnt_r <= POST_RESET;
                    specialTrigger <= 1'b1;
                end else begin
                    postCnt_r <= postCnt_r + 4'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data
    always_ff @(posedge clock) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                FAULT_CFG_ADDR: begin
                    prdata <= {24'h0, faultCfg_r};
                end
                CONTROL_ADDR: begin
                    prdata <= {24'h0, control_r};
                end
                TRIG_CMP_LO_ADDR: begin
                    prdata <= {24'h0, trigCmp_r[7:0]};
                end
                TRIG_CMP_HI_ADDR: begin
                    prdata <= {24'h0, trigCmp_r[15:8]};
                end
                PERIOD_ADDR: begin
                    prdata <= {16'h0, periodBuf_r};
                end
                STATUS_ADDR: begin
                    prdata <= {29'h0, brkFault, faultB, faultA};
                end
                default: begin
                    prdata <= 32'h0;
                    for (int i = 0; i < DUTY_CNT; i++) begin
                        if (paddr == DUTY0_ADDR + 12'(4 * i)) begin
                            prdata <= {16'h0, dutyBuf_r[i]};
                        end
                    end
                end
            endcase
        end
    end
    logic unusedRd;
    assign unusedRd = rdStrobe;
endmodule : pfl_fault_lockout_trigger

/* File: pfl_checker_sva.sv */
// assertion checker for the pwm fault, lockout and trigger block
// assumes it sees only the top ports; register state is mirrored from apb writes
module pfl_checker (
    input wire logic clock,
    input wire logic rst,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic faultInANeg,
    input wire pfl_pkg::pfl_straps_t straps,
    input wire pfl_pkg::pfl_time_base_t timeBase,
    input wire logic [7:0] pwmRaw,
    input wire logic [7:0] pwmOut,
    input wire logic specialTrigger
);
    timeunit 1ns;
    timeprecision 1ns;
    import pfl_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [7:0] cfg_r, ctl_r;
    logic [15:0] cmp_r;
    logic [7:0] inact;
    logic hit, keepUpper;
    assign inact = {4{!straps.highSidePolarity, !straps.lowSidePolarity}};
    assign hit = timeBase.count == cmp_r && (timeBase.mode < TB_UPDOWN || timeBase.countDown == ctl_r[TRIG_DIR_BIT]);
    assign keepUpper = (!cfg_r[SCOPE_BIT] && !cfg_r[BRK_EN_BIT]) || !straps.eightOutputs;
    ////////////////////////////////////////////////////////////////
    // shadow copies only of accepted writes; refused ones change nothing
    always_ff @(posedge clock) begin
        if (rst) begin
            cfg_r <= FAULT_CFG_RESET;
            ctl_r <= CONTROL_RESET;
            cmp_r <= VALUE_RESET;
        end else if (psel && penable && pready && pwrite && !pslverr) begin
            if (paddr == FAULT_CFG_ADDR) cfg_r <= pwdata[7:0];
            if (paddr == CONTROL_ADDR) ctl_r <= pwdata[7:0];
            if (paddr == TRIG_CMP_LO_ADDR) cmp_r[7:0] <= pwdata[7:0];
            if (paddr == TRIG_CMP_HI_ADDR) cmp_r[15:8] <= pwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////
    sequence s_fault_held; (cfg_r[FA_EN_BIT] && cfg_r[SCOPE_BIT] && straps.eightOutputs && !faultInANeg)[*6]; endsequence
    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("setup not answered");
    property p_ready_one; pready |=> !pready; endproperty
    a_ready_one: assert property (p_ready_one) else $error("ready too long");
    property p_err_ready; pslverr |-> pready; endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_level; !$past(rst) |-> ((pwmOut ^ inact) & ~$past(pwmRaw)) == 8'h00; endproperty
    a_level: assert property (p_level) else $error("output at wrong level");
    property p_upper; !$past(rst) && keepUpper && $past(keepUpper) && $past(keepUpper, 2)
        |-> pwmOut[7:6] == ($past(pwmRaw[7:6]) ^ inact[7:6]); endproperty
    a_upper: assert property (p_upper) else $error("upper pair forced");
    property p_force_all; s_fault_held |-> pwmOut == inact; endproperty
    a_force_all: assert property (p_force_all) else $error("fault not forcing");
    property p_trig_cause; specialTrigger |-> $past(hit); endproperty
    a_trig_cause: assert property (p_trig_cause) else $error("trigger without match");
    property p_trig_every; !$past(rst) && $past(hit) && $past(ctl_r[7:4]) == 4'h0
        && !$past(psel && penable && pwrite && (paddr == TRIG_CMP_LO_ADDR || paddr == TRIG_CMP_HI_ADDR))
        |-> specialTrigger; endproperty
    a_trig_every: assert property (p_trig_every) else $error("match without trigger");
endmodule : pfl_checker

bind pfl_fault_lockout_trigger pfl_checker u_chk (.*);

/* File: pfl_partner.sv */
// far side: fault sources on pulled-up lines, time base and pwm generator
// assumes the bench picks the time base mode and raises fault requests
module pfl_partner #(parameter int PER = 16) (
    input wire logic clock,
    input wire logic rst,
    input wire pfl_pkg::pfl_tb_mode_t mode,
    input wire logic [1:0] faultReq,
    output logic faultInANeg,
    output logic faultInBNeg,
    output pfl_pkg::pfl_time_base_t timeBase,
    output logic [7:0] pwmRaw
);
    timeunit 1ns;
    timeprecision 1ns;
    import pfl_pkg::*;
    // a source only pulls low; released, the pull-up brings the line high
    assign faultInANeg = !faultReq[0];
    assign faultInBNeg = !faultReq[1];
    assign pwmRaw = timeBase.count[7:0] ^ 8'h5a;
    always_ff @(posedge clock) begin
        if (rst) begin
            timeBase <= '0;
        end else begin
            timeBase.mode <= mode;
            timeBase.periodStart <= 1'b0;
            if (timeBase.countDown) begin
                timeBase.count <= timeBase.count - 16'h0001;
                timeBase.countDown <= timeBase.count != 16'h0001;
                timeBase.periodStart <= timeBase.count == 16'h0001;
            end else if (timeBase.count == 16'(PER - 1)) begin
                timeBase.countDown <= mode >= TB_UPDOWN;
                timeBase.count <= (mode >= TB_UPDOWN) ? timeBase.count - 16'h0001 : 16'h0000;
                timeBase.periodStart <= mode < TB_UPDOWN;
            end else begin
                timeBase.count <= timeBase.count + 16'h0001;
            end
        end
    end
endmodule : pfl_partner

/* File: pfl_fault_lockout_trigger_tb.sv */
// self-checking bench for the pwm fault, lockout and trigger block
// assumes the partner model supplies time base, raw pwm and fault lines
module pfl_fault_lockout_trigger_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import pfl_pkg::*;
    localparam int PER = 16;
    localparam logic [7:0] INACT = 8'h55;
    logic clock = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, breakpointHit = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, specialTrigger, faultInANeg, faultInBNeg;
    logic [1:0] faultReq = 2'h0;
    pfl_tb_mode_t mode = TB_FREE;
    pfl_straps_t straps = 4'hb;
    pfl_time_base_t timeBase;
    logic [7:0] pwmRaw, pwmOut;
    logic [15:0] periodActive;
    logic [15:0] dutyActive [DUTY_CNT];
    int errors = 0, n_compared = 0, cycles = 0;
    pfl_fault_lockout_trigger dut (.*);
    pfl_partner #(.PER(PER)) far (.*);
    always #5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("MISMATCH %0t timeout", $time);
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n); repeat (n) @(posedge clock); endtask : cyc
    // one edge passes after release so back-to-back calls never rewrite psel in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q, output logic e);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        logic [31:0] q;
        logic e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp, what);
    endtask : rd
    task automatic follow(input string what);
        logic [7:0] q;
        #1 q = pwmRaw;
        @(posedge clock);
        #1 chk(pwmOut, q ^ INACT, what);
        @(posedge clock);
    endtask : follow
    ////////////////////////////////////////////////////////////////
    task automatic t_inactive;
        logic [31:0] q;
        logic e;
        rd(FAULT_CFG_ADDR, 32'h00, "cfg reset");
        apb(1'b0, 12'h0fc, 32'h0, q, e);
        chk(e, 1'b1, "unmapped err");
        chk(q, 32'h0, "unmapped data");
        wr(FAULT_CFG_ADDR, 32'h09);
        faultReq <= 2'h1;
        cyc(8);
        chk(pwmOut, INACT, "all forced");
        rd(FAULT_CFG_ADDR, 32'h0d, "flag set");
        wr(FAULT_CFG_ADDR, 32'h09);
        rd(FAULT_CFG_ADDR, 32'h0d, "flag kept live");
        faultReq <= 2'h0;
        cyc(3 * PER);
        chk(pwmOut, INACT, "held");
        wr(FAULT_CFG_ADDR, 32'h09);
        rd(FAULT_CFG_ADDR, 32'h09, "flag cleared");
        cyc(2 * PER);
        follow("released");
        $display("inactive mode done");
    endtask : t_inactive
    task automatic t_cycle(input logic b);
        logic [31:0] c;
        c = b ? 32'h38 : 32'h0b;
        wr(FAULT_CFG_ADDR, c);
        faultReq <= b ? 2'h2 : 2'h1;
        cyc(8);
        chk(pwmOut, INACT, "cycle forced");
        rd(FAULT_CFG_ADDR, c | (b ? 32'h40 : 32'h04), "cycle flag");
        faultReq <= 2'h0;
        cyc(2 * PER + 8);
        rd(FAULT_CFG_ADDR, c, "auto clear");
        follow("cycle release");
        $display("cycle mode done");
    endtask : t_cycle
    task automatic t_other;
        wr(FAULT_CFG_ADDR, 32'h01);
        faultReq <= 2'h1;
        cyc(8);
        chk(pwmOut[5:0], INACT[5:0], "low six");
        faultReq <= 2'h0;
        cyc(4);
        wr(FAULT_CFG_ADDR, 32'h00);
        faultReq <= 2'h3;
        cyc(2 * PER);
        follow("disabled");
        faultReq <= 2'h0;
        wr(FAULT_CFG_ADDR, 32'h88);
        breakpointHit <= 1'b1;
        cyc(8);
        chk(pwmOut, INACT, "breakpoint");
        breakpointHit <= 1'b0;
        cyc(8);
        follow("breakpoint off");
        $display("scope and breakpoint done");
    endtask : t_other
    task automatic t_lock;
        wr(PERIOD_ADDR, 32'h40);
        cyc(2);
        chk(periodActive, 16'h0040, "period open");
        wr(CONTROL_ADDR, 32'h02);
        wr(PERIOD_ADDR, 32'h50);
        wr(DUTY0_ADDR + 12'h00c, 32'h33);
        cyc(2);
        chk(periodActive, 16'h0040, "period held");
        chk(dutyActive[3], 16'h0000, "duty held");
        wr(CONTROL_ADDR, 32'h00);
        cyc(2);
        chk(periodActive, 16'h0050, "period loaded");
        chk(dutyActive[3], 16'h0033, "duty loaded");
        $display("lockout done");
    endtask : t_lock
    task automatic t_trig;
        int n = 0;
        wr(CONTROL_ADDR, 32'h20);
        wr(TRIG_CMP_LO_ADDR, 32'h05);
        repeat (6 * PER + 2) begin
            @(posedge clock);
            if (specialTrigger === 1'b1) n++;
        end
        chk(n, 2, "postscaled pulses");
        mode <= TB_UPDOWN;
        wr(CONTROL_ADDR, 32'h08);
        wr(TRIG_CMP_HI_ADDR, 32'h00);
        cyc(2 * PER);
        n = 0;
        repeat (120) begin
            @(posedge clock);
            if (specialTrigger === 1'b1) begin
                n++;
                chk(timeBase.countDown, 1'b1, "trigger phase");
            end
        end
        chk(n, 4, "down-phase pulses");
        $display("trigger done");
    endtask : t_trig
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : summarize
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        t_inactive();
        t_cycle(1'b0);
        t_cycle(1'b1);
        t_other();
        t_lock();
        t_trig();
        summarize();
    end
endmodule : pfl_fault_lockout_trigger_tb
